// ---- hw/vis_edge_det.sv ----
// valid-edge detector for one request pin
`timescale 1ns/1ps
module vis_edge_det (
	input wire logic CLK_SYS,
	input wire logic RST_N,
	vis_edge_if.det  bus
);

	typedef struct packed {
		logic prev;
		logic armed;
	} vis_edge_state_type;

	vis_edge_state_type st_r;
	vis_edge_state_type st_nxt;
	logic               rise;
	logic               fall;

	always_comb begin
		st_nxt       = st_r;
		st_nxt.prev  = bus.pin;
		st_nxt.armed = 1'b1;
		// no edge until a first sample exists, else a high pin fakes one
		rise = st_r.armed & bus.pin & ~st_r.prev;
		fall = st_r.armed & ~bus.pin & st_r.prev;
		case (bus.mode)
			vis_pkg::EDGE_FALL: bus.pulse = fall;
			vis_pkg::EDGE_RISE: bus.pulse = rise;
			vis_pkg::EDGE_BOTH: bus.pulse = rise | fall;
			default:            bus.pulse = 1'b0;
		endcase
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule : vis_edge_det

// ---- hw/vis_edge_if.sv ----
// pin edge detection carrier between the controller and its detectors
`timescale 1ns/1ps
interface vis_edge_if;
	logic                       pin;
	vis_pkg::vis_edge_mode_type mode;
	logic                       pulse;

	modport det (
		input  pin,
		input  mode,
		output pulse
	);

	modport user (
		output pin,
		output mode,
		input  pulse
	);
endinterface : vis_edge_if

// ---- hw/vis_intc.sv ----
// vectored maskable interrupt and reset source logic
`timescale 1ns/1ps
module vis_intc #(
	parameter bit LARGE_VARIANT = 1'b1
) (
	input  wire logic        CLK_SYS,
	input  wire logic        RST_N,
	input  wire logic [15:0] REG_ADDR,
	input  wire logic [7:0]  REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output wire logic [7:0]  REG_RDATA,
	input  wire logic        EXT_PIN_A,
	input  wire logic        EXT_PIN_B,
	input  wire logic        LOW_VOLTAGE_DETECTOR,
	input  wire logic        TIMER8_MATCH,
	input  wire logic        T16_MATCH_A,
	input  wire logic        T16_MATCH_B,
	input  wire logic        T16_CAPTURE_MODE_A,
	input  wire logic        T16_CAPTURE_MODE_B,
	input  wire logic        CAPTURE_PIN_A,
	input  wire logic        CAPTURE_PIN_B,
	input  wire logic        CONVERSION_DONE,
	input  wire logic        POWER_ON_CLEAR,
	input  wire logic        WATCHDOG_OVERFLOW,
	input  wire logic        VEC_ACK,
	output wire logic        VEC_REQ,
	output wire logic [15:0] VEC_ADDR,
	output wire logic        PSW_PUSH,
	output wire logic [7:0]  PSW_PUSH_DATA,
	output wire logic        GLOBAL_IRQ_ENABLE,
	output wire logic        STANDBY_RELEASE,
	output wire logic        CORE_RESET,
	output wire logic [15:0] BOOT_VEC_ADDR,
	output wire logic [1:0]  ANALOG_CHANNEL_SELECT
);

	typedef struct packed {
		logic [7:0]  req_flags;
		logic [7:0]  mask_flags;
		logic [7:0]  edge_mode;
		logic [7:0]  processor_status_word;
		logic        lv_sel;
		logic [1:0]  chan_sel;
		logic [7:0]  rdata;
		logic        vec_req;
		logic [2:0]  vec_idx;
		logic [15:0] vec_addr;
		logic        push;
		logic [7:0]  push_data;
		logic        standby;
		logic        core_rst;
	} vis_state_type;

	localparam logic [7:0] IMPL = LARGE_VARIANT ? vis_pkg::IMPL_LARGE
	                                            : vis_pkg::IMPL_SMALL;

	// smallest set index wins; bit 0 is never a source
	function automatic logic [2:0] pick_source(input logic [7:0] pend);
		logic [2:0] idx;
		idx = 3'h0;
		for (int i = 7; i >= 1; i--) begin
			if (pend[i]) begin
				idx = 3'(i);
			end
		end
		return idx;
	endfunction : pick_source

	function automatic logic [15:0] vector_of(input logic [2:0] idx);
		logic [15:0] v;
		case (idx)
			3'(vis_pkg::BIT_LOW_VOLTAGE): v = vis_pkg::VEC_LOW_VOLTAGE;
			3'(vis_pkg::BIT_EXT_A):       v = vis_pkg::VEC_EXT_A;
			3'(vis_pkg::BIT_EXT_B):       v = vis_pkg::VEC_EXT_B;
			3'(vis_pkg::BIT_TIMER8):      v = vis_pkg::VEC_TIMER8;
			3'(vis_pkg::BIT_T16_A):       v = vis_pkg::VEC_T16_A;
			3'(vis_pkg::BIT_T16_B):       v = vis_pkg::VEC_T16_B;
			3'(vis_pkg::BIT_CONV_DONE):   v = vis_pkg::VEC_CONV_DONE;
			default:                      v = vis_pkg::VEC_RESET;
		endcase
		return v;
	endfunction : vector_of

	function automatic vis_state_type reset_state();
		vis_state_type s;
		s            = '0;
		s.req_flags  = vis_pkg::RST_REQ_FLAGS;
		s.mask_flags = vis_pkg::RST_MASK_FLAGS;
		s.edge_mode  = vis_pkg::RST_EDGE_MODE;
		s.processor_status_word        = vis_pkg::RST_PSW;
		s.chan_sel   = vis_pkg::RST_CHAN_SEL;
		s.vec_addr   = vis_pkg::VEC_RESET;
		s.core_rst   = 1'b1;
		return s;
	endfunction : reset_state

	vis_state_type st_r;
	vis_state_type st_nxt;
	logic [7:0]    events;
	logic [7:0]    pend;
	logic          ack;
	logic          hard_rst;
	logic          soft_rst;

	// detectors: 0 pin A, 1 pin B, 2 capture A, 3 capture B, 4 low voltage
	localparam int NUM_DET = 5;

	vis_edge_if eif [NUM_DET] ();

	assign eif[0].pin  = EXT_PIN_A;
	assign eif[0].mode = vis_pkg::vis_edge_mode_type'(
		st_r.edge_mode[vis_pkg::EXT_A_MODE_LSB +: 2]);
	assign eif[1].pin  = EXT_PIN_B;
	assign eif[1].mode = vis_pkg::vis_edge_mode_type'(
		st_r.edge_mode[vis_pkg::EXT_B_MODE_LSB +: 2]);
	// capture edge polarity lives in the timer; here any rise is valid
	assign eif[2].pin  = CAPTURE_PIN_A;
	assign eif[2].mode = vis_pkg::EDGE_RISE;
	assign eif[3].pin  = CAPTURE_PIN_B;
	assign eif[3].mode = vis_pkg::EDGE_RISE;
	assign eif[4].pin  = LOW_VOLTAGE_DETECTOR;
	assign eif[4].mode = vis_pkg::EDGE_RISE;

	for (genvar g = 0; g < NUM_DET; g++) begin : g_det
		vis_edge_det u_det (
			.CLK_SYS (CLK_SYS),
			.RST_N   (RST_N),
			.bus     (eif[g])
		);
	end

	always_comb begin
		events = 8'h00;
		events[vis_pkg::BIT_LOW_VOLTAGE] = eif[4].pulse & ~st_r.lv_sel;
		events[vis_pkg::BIT_EXT_A]       = eif[0].pulse;
		events[vis_pkg::BIT_EXT_B]       = eif[1].pulse;
		events[vis_pkg::BIT_TIMER8]      = TIMER8_MATCH;
		events[vis_pkg::BIT_T16_A]       = T16_CAPTURE_MODE_A ? eif[3].pulse
		                                                      : T16_MATCH_A;
		events[vis_pkg::BIT_T16_B]       = T16_CAPTURE_MODE_B ? eif[2].pulse
		                                                      : T16_MATCH_B;
		events[vis_pkg::BIT_CONV_DONE]   = CONVERSION_DONE;
	end

	always_comb begin
		st_nxt   = st_r;
		pend     = 8'h00;
		ack      = 1'b0;
		hard_rst = POWER_ON_CLEAR;
		soft_rst = WATCHDOG_OVERFLOW
		         | (LOW_VOLTAGE_DETECTOR & st_r.lv_sel);
		st_nxt.push  = 1'b0;
		st_nxt.rdata = 8'h00;
		if (hard_rst || soft_rst) begin
			st_nxt = reset_state();
			// a low-voltage reset must not forget that it chose reset mode
			st_nxt.lv_sel = hard_rst ? 1'b0 : st_r.lv_sel;
		end else begin
			st_nxt.core_rst = 1'b0;
			ack = VEC_ACK & st_r.vec_req;
			if (ack) begin
				st_nxt.req_flags[st_r.vec_idx] = 1'b0;
				st_nxt.push_data = st_r.processor_status_word;
				st_nxt.push      = 1'b1;
				st_nxt.processor_status_word[vis_pkg::PSW_IE_BIT] = 1'b0;
			end
			if (REG_WR) begin
				case (REG_ADDR)
					vis_pkg::ADDR_REQ_FLAGS:
						st_nxt.req_flags = REG_WDATA & IMPL;
					vis_pkg::ADDR_MASK_FLAGS:
						st_nxt.mask_flags = REG_WDATA | ~IMPL;
					vis_pkg::ADDR_EDGE_MODE:
						st_nxt.edge_mode = REG_WDATA & vis_pkg::EDGE_MODE_WMASK;
					vis_pkg::ADDR_LV_CTRL:
						st_nxt.lv_sel = REG_WDATA[vis_pkg::LV_SEL_BIT];
					vis_pkg::ADDR_CHAN_SEL:
						st_nxt.chan_sel = REG_WDATA[1:0];
					vis_pkg::ADDR_PSW:
						st_nxt.processor_status_word = REG_WDATA;
					default: ;
				endcase
			end
			// hardware set wins over a software or acknowledge clear
			st_nxt.req_flags = st_nxt.req_flags | (events & IMPL);
			pend = st_nxt.req_flags & ~st_nxt.mask_flags & IMPL;
			st_nxt.standby  = |pend;
			st_nxt.vec_idx  = pick_source(pend);
			st_nxt.vec_req  = (|pend) & st_nxt.processor_status_word[vis_pkg::PSW_IE_BIT];
			st_nxt.vec_addr = vector_of(st_nxt.vec_idx);
		end
		if (REG_RD) begin
			case (REG_ADDR)
				vis_pkg::ADDR_REQ_FLAGS:  st_nxt.rdata = st_r.req_flags;
				vis_pkg::ADDR_MASK_FLAGS: st_nxt.rdata = st_r.mask_flags;
				vis_pkg::ADDR_EDGE_MODE:  st_nxt.rdata = st_r.edge_mode;
				vis_pkg::ADDR_LV_CTRL: begin
					st_nxt.rdata = 8'h00;
					st_nxt.rdata[vis_pkg::LV_SEL_BIT] = st_r.lv_sel;
				end
				vis_pkg::ADDR_CHAN_SEL:   st_nxt.rdata = {6'h00, st_r.chan_sel};
				vis_pkg::ADDR_PSW:        st_nxt.rdata = st_r.processor_status_word;
				default:                  st_nxt.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			st_r <= reset_state();
		end else begin
			st_r <= st_nxt;
		end
	end

	assign REG_RDATA             = st_r.rdata;
	assign VEC_REQ               = st_r.vec_req;
	assign VEC_ADDR              = st_r.vec_addr;
	assign PSW_PUSH              = st_r.push;
	assign PSW_PUSH_DATA         = st_r.push_data;
	assign GLOBAL_IRQ_ENABLE     = st_r.processor_status_word[vis_pkg::PSW_IE_BIT];
	assign STANDBY_RELEASE       = st_r.standby;
	assign CORE_RESET            = st_r.core_rst;
	// start address is read from the byte pair at this word and the next
	assign BOOT_VEC_ADDR         = vis_pkg::VEC_RESET;
	assign ANALOG_CHANNEL_SELECT = st_r.chan_sel;

endmodule : vis_intc

// ---- hw/vis_pkg.sv ----
// shared constants for the vectored interrupt source logic
package vis_pkg;

	// register map (byte addresses on the 16-bit register port)
	localparam logic [15:0] ADDR_REQ_FLAGS  = 16'hFFE0;
	localparam logic [15:0] ADDR_MASK_FLAGS = 16'hFFE4;
	localparam logic [15:0] ADDR_EDGE_MODE  = 16'hFFEC;
	localparam logic [15:0] ADDR_LV_CTRL    = 16'hFFF0;
	localparam logic [15:0] ADDR_CHAN_SEL   = 16'hFFF4;
	localparam logic [15:0] ADDR_PSW        = 16'hFFF8;

	// reset values
	localparam logic [7:0] RST_REQ_FLAGS  = 8'h00;
	localparam logic [7:0] RST_MASK_FLAGS = 8'hFF;
	localparam logic [7:0] RST_EDGE_MODE  = 8'h00;
	localparam logic [7:0] RST_PSW        = 8'h02;
	localparam logic [1:0] RST_CHAN_SEL   = 2'h0;

	// flag bit positions, shared by request and mask registers
	localparam int BIT_LOW_VOLTAGE = 1;
	localparam int BIT_EXT_A       = 2;
	localparam int BIT_EXT_B       = 3;
	localparam int BIT_TIMER8      = 4;
	localparam int BIT_T16_A       = 5;
	localparam int BIT_T16_B       = 6;
	localparam int BIT_CONV_DONE   = 7;

	// implemented flags per device variant
	localparam logic [7:0] IMPL_LARGE = 8'hFE;
	localparam logic [7:0] IMPL_SMALL = 8'h1E;

	// field positions
	localparam int PSW_IE_BIT      = 7;
	localparam int LV_SEL_BIT      = 1;
	localparam int EXT_A_MODE_LSB  = 2;
	localparam int EXT_B_MODE_LSB  = 4;
	localparam logic [7:0] EDGE_MODE_WMASK = 8'h3C;

	// vector table entries
	localparam logic [15:0] VEC_RESET       = 16'h0000;
	localparam logic [15:0] VEC_LOW_VOLTAGE = 16'h0006;
	localparam logic [15:0] VEC_EXT_A       = 16'h0008;
	localparam logic [15:0] VEC_EXT_B       = 16'h000A;
	localparam logic [15:0] VEC_TIMER8      = 16'h000C;
	localparam logic [15:0] VEC_T16_A       = 16'h000E;
	localparam logic [15:0] VEC_T16_B       = 16'h0010;
	localparam logic [15:0] VEC_CONV_DONE   = 16'h0012;

	typedef enum logic [1:0] {
		EDGE_FALL = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_NONE = 2'b10,
		EDGE_BOTH = 2'b11
	} vis_edge_mode_type;

endpackage : vis_pkg

// ---- sim/vis_core_model.sv ----
// behavioural core that answers vector requests after a chosen delay
`timescale 1ns/1ps
module vis_core_model (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        vec_req,
	input wire logic [15:0] vec_addr,
	input wire logic [3:0]  delay,
	output logic            vec_ack,
	output logic [15:0]     taken_addr
);
	logic [3:0] wait_cnt;

	// ack is a one-cycle pulse; only a standing request makes it count
	always @(posedge clk) begin
		if (!rst_n) begin
			vec_ack <= 1'b0;
			wait_cnt <= 4'h0;
			taken_addr <= 16'h0000;
		end else if (vec_ack) begin
			vec_ack <= 1'b0;
			if (vec_req)
				taken_addr <= vec_addr;
		end else if (vec_req && wait_cnt >= delay) begin
			vec_ack <= 1'b1;
			wait_cnt <= 4'h0;
		end else if (vec_req) begin
			wait_cnt <= wait_cnt + 4'h1;
		end
	end
endmodule : vis_core_model

// ---- sim/vis_intc_asserts.sv ----
// concurrent checks on the interrupt logic ports
`timescale 1ns/1ps
module vis_intc_asserts (
	input wire logic        CLK_SYS,
	input wire logic        RST_N,
	input wire logic        POWER_ON_CLEAR,
	input wire logic        WATCHDOG_OVERFLOW,
	input wire logic        VEC_ACK,
	input wire logic        VEC_REQ,
	input wire logic [15:0] VEC_ADDR,
	input wire logic        PSW_PUSH,
	input wire logic [7:0]  PSW_PUSH_DATA,
	input wire logic        GLOBAL_IRQ_ENABLE,
	input wire logic        STANDBY_RELEASE,
	input wire logic        CORE_RESET,
	input wire logic [15:0] BOOT_VEC_ADDR
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);

	ack_push_a: assert property (VEC_REQ && VEC_ACK |=> PSW_PUSH)
		else $error("no status push after acknowledge");
	push_ie_a: assert property (VEC_REQ && VEC_ACK |=> !GLOBAL_IRQ_ENABLE
		&& PSW_PUSH_DATA[7])
		else $error("enable not cleared or wrong pushed status");
	push_cause_a: assert property ($rose(PSW_PUSH) |->
		$past(VEC_REQ) && $past(VEC_ACK))
		else $error("status push without accepted acknowledge");
	wake_with_req_a: assert property ($rose(VEC_REQ) |-> STANDBY_RELEASE)
		else $error("vector request without standby release");
	vec_table_a: assert property (VEC_REQ |-> VEC_ADDR inside {16'h0006,
		16'h0008, 16'h000A, 16'h000C, 16'h000E, 16'h0010, 16'h0012})
		else $error("vector address outside the table");
	req_needs_ie_a: assert property (VEC_REQ |-> GLOBAL_IRQ_ENABLE)
		else $error("vector request while global enable is off");
	boot_vec_a: assert property (BOOT_VEC_ADDR == 16'h0000)
		else $error("boot vector not zero");
	por_reset_a: assert property (POWER_ON_CLEAR |=> CORE_RESET)
		else $error("power-on clear gave no core reset");
	wdt_reset_a: assert property (WATCHDOG_OVERFLOW |=> CORE_RESET)
		else $error("watchdog overflow gave no core reset");
	reset_quiet_a: assert property ($fell(CORE_RESET) |->
		!STANDBY_RELEASE && !VEC_REQ)
		else $error("request active straight after reset");

	cover property (VEC_REQ && VEC_ACK);
	cover property (CORE_RESET && WATCHDOG_OVERFLOW);
	cover property (STANDBY_RELEASE && !VEC_REQ);
endmodule : vis_intc_asserts

bind vis_intc vis_intc_asserts u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
	.POWER_ON_CLEAR(POWER_ON_CLEAR), .WATCHDOG_OVERFLOW(WATCHDOG_OVERFLOW),
	.VEC_ACK(VEC_ACK), .VEC_REQ(VEC_REQ), .VEC_ADDR(VEC_ADDR),
	.PSW_PUSH(PSW_PUSH), .PSW_PUSH_DATA(PSW_PUSH_DATA),
	.GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .STANDBY_RELEASE(STANDBY_RELEASE),
	.CORE_RESET(CORE_RESET), .BOOT_VEC_ADDR(BOOT_VEC_ADDR));

// ---- sim/vis_intc_test.sv ----
// register-level testbench for the vectored interrupt logic
`timescale 1ns/1ps
module vis_intc_test;
	logic        clk, rst_n, wr, rd, ack, req, push, ie, stby, crst;
	logic [15:0] addr, vaddr, boot, taken;
	logic [7:0]  wdata, rdata, pdata, rdata_s;
	logic [6:0]  src;
	logic [2:0]  rsrc;
	logic [1:0]  chan;
	logic [3:0]  dly, cap;
	int          err_count, checks_done;
	logic [15:0] vec_exp [7] = '{16'h0006, 16'h0008, 16'h000A, 16'h000C,
		16'h000E, 16'h0010, 16'h0012};

	vis_intc dut (.CLK_SYS(clk), .RST_N(rst_n), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
		.EXT_PIN_A(src[1]), .EXT_PIN_B(src[2]),
		.LOW_VOLTAGE_DETECTOR(src[0] | rsrc[1]), .TIMER8_MATCH(src[3]),
		.T16_MATCH_A(src[4]), .T16_MATCH_B(src[5]),
		.T16_CAPTURE_MODE_A(cap[0]), .T16_CAPTURE_MODE_B(cap[1]),
		.CAPTURE_PIN_A(cap[2]), .CAPTURE_PIN_B(cap[3]), .CONVERSION_DONE(src[6]),
		.POWER_ON_CLEAR(rsrc[2]), .WATCHDOG_OVERFLOW(rsrc[0]), .VEC_ACK(ack),
		.VEC_REQ(req), .VEC_ADDR(vaddr), .PSW_PUSH(push),
		.PSW_PUSH_DATA(pdata), .GLOBAL_IRQ_ENABLE(ie), .STANDBY_RELEASE(stby),
		.CORE_RESET(crst), .BOOT_VEC_ADDR(boot), .ANALOG_CHANNEL_SELECT(chan));
	vis_core_model core (.clk(clk), .rst_n(rst_n), .vec_req(req),
		.vec_addr(vaddr), .delay(dly), .vec_ack(ack), .taken_addr(taken));
	// second build without the 16-bit channels and conversion request
	vis_intc #(.LARGE_VARIANT(1'b0)) dut_small (.CLK_SYS(clk), .RST_N(rst_n),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
		.REG_RDATA(rdata_s), .EXT_PIN_A(src[1]), .EXT_PIN_B(src[2]),
		.LOW_VOLTAGE_DETECTOR(src[0] | rsrc[1]), .TIMER8_MATCH(src[3]),
		.T16_MATCH_A(src[4]), .T16_MATCH_B(src[5]),
		.T16_CAPTURE_MODE_A(cap[0]), .T16_CAPTURE_MODE_B(cap[1]),
		.CAPTURE_PIN_A(cap[2]), .CAPTURE_PIN_B(cap[3]),
		.CONVERSION_DONE(src[6]), .POWER_ON_CLEAR(rsrc[2]),
		.WATCHDOG_OVERFLOW(rsrc[0]), .VEC_ACK(1'b0), .VEC_REQ(),
		.VEC_ADDR(), .PSW_PUSH(), .PSW_PUSH_DATA(), .GLOBAL_IRQ_ENABLE(),
		.STANDBY_RELEASE(), .CORE_RESET(), .BOOT_VEC_ADDR(),
		.ANALOG_CHANNEL_SELECT());

	task chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task rd_reg(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk({8'h00, rdata}, {8'h00, exp});
	endtask : rd_reg
	task pulse(input logic [6:0] v);
		@(posedge clk);
		src <= v;
		@(posedge clk);
		src <= 7'h00;
	endtask : pulse
	// bounded wait so a lost acknowledge shows as a mismatch, not a hang
	task wait_push;
		for (int n = 0; n < 40 && push !== 1'b1; n++)
			@(negedge clk);
		chk({15'h0, push}, 16'h0001);
	endtask : wait_push
	task report_and_stop;
		$display("mismatches %0d, comparisons %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#80000;
		err_count++;
		report_and_stop;
	end
	initial begin
		{rst_n, wr, rd, src, rsrc, dly, cap, addr, wdata} = '0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(16'hFFE4, 8'hFF);
		rd_reg(16'hFFF8, 8'h02);
		rd_reg(16'hFFE0, 8'h00);
		rd_reg(16'hFF00, 8'h00);
		wr_reg(16'hFFE0, 8'hFE);
		rd_reg(16'hFFE0, 8'hFE);
		chk({8'h00, rdata_s}, 16'h001E);
		wr_reg(16'hFFE0, 8'h00);
		wr_reg(16'hFFEC, 8'h14);
		wr_reg(16'hFFE4, 8'h00);
		rd_reg(16'hFFE4, 8'h01);
		chk({8'h00, rdata_s}, 16'h00E1);
		wr_reg(16'hFFF8, 8'h82);
		pulse(7'h7F);
		for (int i = 0; i < 7; i++) begin
			dly <= i[0] ? 4'h3 : 4'h0;
			wait_push;
			chk(taken, vec_exp[i]);
			chk({8'h00, pdata}, 16'h0082);
			chk({15'h0, ie}, 16'h0000);
			wr_reg(16'hFFF8, 8'h82);
		end
		// pin A off, pin B on both edges, then both pins on falling edge
		wr_reg(16'hFFF8, 8'h00);
		wr_reg(16'hFFEC, 8'h38);
		pulse(7'h06);
		rd_reg(16'hFFE0, 8'h08);
		wr_reg(16'hFFE0, 8'h00);
		wr_reg(16'hFFEC, 8'h00);
		pulse(7'h02);
		rd_reg(16'hFFE0, 8'h04);
		wr_reg(16'hFFE0, 8'h00);
		// capture configuration: matches ignored, crossed pins request
		@(posedge clk);
		cap <= 4'h3;
		pulse(7'h30);
		cap <= 4'hB;
		@(posedge clk);
		cap <= 4'h3;
		rd_reg(16'hFFE0, 8'h20);
		@(posedge clk);
		cap <= 4'h7;
		@(posedge clk);
		cap <= 4'h0;
		rd_reg(16'hFFE0, 8'h60);
		wr_reg(16'hFFE0, 8'h00);
		wr_reg(16'hFFE4, 8'h10);
		pulse(7'h08);
		repeat (3) @(negedge clk);
		chk({14'h0, req, stby}, 16'h0000);
		rd_reg(16'hFFE0, 8'h10);
		wr_reg(16'hFFF8, 8'h00);
		wr_reg(16'hFFE4, 8'h00);
		repeat (2) @(negedge clk);
		chk({15'h0, req}, 16'h0000);
		chk({15'h0, stby}, 16'h0001);
		wr_reg(16'hFFF8, 8'h82);
		wait_push;
		chk(taken, 16'h000C);
		wr_reg(16'hFFE4, 8'h80);
		pulse(7'h40);
		wr_reg(16'hFFF4, 8'h03);
		rd_reg(16'hFFE0, 8'h80);
		chk({14'h0, chan}, 16'h0003);
		wr_reg(16'hFFE0, 8'h00);
		rd_reg(16'hFFE0, 8'h00);
		wr_reg(16'hFFF0, 8'h02);
		for (int i = 0; i < 3; i++) begin
			wr_reg(16'hFFE4, 8'h00);
			@(posedge clk);
			rsrc <= 3'(1 << i);
			repeat (2) @(posedge clk);
			@(negedge clk);
			chk({15'h0, crst}, 16'h0001);
			@(posedge clk);
			rsrc <= 3'h0;
			repeat (3) @(posedge clk);
			rd_reg(16'hFFE4, 8'hFF);
			rd_reg(16'hFFF0, i < 2 ? 8'h02 : 8'h00);
		end
		report_and_stop;
	end
endmodule : vis_intc_test
